// File: ecctmr_timer.sv
// Edge-cleared capture/compare timer with its input filters and Avalon-MM register slave.
// Operation
// - Mode 10: count, clear on primary edge
// - Inputs need two equal samples per edge
// - Compare matches raise irq zero, irq one
// - Capture zero on secondary or reverse phase
// - Primary valid edge captures register one
// - Counter clears after primary edge capture
// - Toggle on matches, optionally on clear
// - Clear toggle plus match gives pulse
// - Clear on rising, capture falling edge
// - Reverse phase capture raises no interrupt
// - Both-edge primary captures, clears, toggles
// - Compare match changes the counter only in mode 11: match zero clears it
// - Zero takes either pin, one primary
// - Mode 01: free run, overflow flag
// - Overflow flag sticks until software clears
// - Free run supports all register uses
//
// Chosen here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none

module ecctmr_edge_filt (
  input wire logic core_clk_in, // Core clock.
  input wire logic resetn_in, // Synchronous reset, active low.
  input wire logic pin_in, // Asynchronous timer pin.
  input wire logic sample_en_in, // Sampling clock enable.
  output ecctmr_pkg::ecctmr_edge_s edge_out // Accepted edge pulses.
);
  import ecctmr_pkg::*;

  logic sync1_reg;
  logic sync2_reg;
  logic samp_reg;
  logic lvl_reg;
  logic primed_reg;
  logic stable;

  assign stable = sample_en_in && (samp_reg == sync2_reg);

  // The first stable level after reset only seeds the filter, so a pin held high raises no edge when PRS_DIV is 3 or more.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      samp_reg <= 1'b0;
      lvl_reg <= 1'b0;
      primed_reg <= 1'b0;
      edge_out <= '0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      edge_out <= '0;
      if (sample_en_in) begin
        samp_reg <= sync2_reg;
      end
      if (stable && !primed_reg) begin
        primed_reg <= 1'b1;
        lvl_reg <= sync2_reg;
      end else if (stable && lvl_reg != sync2_reg) begin
        lvl_reg <= sync2_reg;
        edge_out.rise <= sync2_reg;
        edge_out.fall <= !sync2_reg;
      end
    end
  end

endmodule

module ecctmr_timer #(
  parameter int unsigned PRS_DIV = ecctmr_pkg::PRS_DIV_DEF
) (
  input wire logic core_clk_in, // Core clock, 250 MHz.
  input wire logic resetn_in, // Synchronous reset, active low.
  input wire logic [ecctmr_pkg::ADDR_W-1:0] avs_address_in, // Byte address.
  input wire logic avs_read_in, // Read request.
  input wire logic avs_write_in, // Write request.
  input wire logic [31:0] avs_writedata_in, // Write data.
  input wire logic [3:0] avs_byteenable_in, // Byte lanes.
  output logic [31:0] avs_readdata_out, // Read data.
  output logic avs_waitrequest_out, // Stall while high.
  input wire logic primary_timer_input_in, // Primary timer pin.
  input wire logic secondary_timer_input_in, // Secondary timer pin.
  output logic timer_output_pin_out, // Timer output pin.
  output logic irq_reg_zero_out, // Register zero event pulse.
  output logic irq_reg_one_out // Register one event pulse.
);
  import ecctmr_pkg::*;

  // ****************************************
  // Registers and configuration view
  // ****************************************
  logic [7:0] timer_mode_control_reg;
  logic [7:0] prescaler_mode_reg;
  logic [7:0] capcmp_control_reg;
  logic [7:0] output_control_reg;
  logic [15:0] up_counter_reg;
  logic [15:0] up_counter_next;
  logic [15:0] capcmp_reg_zero_reg;
  logic [15:0] capcmp_reg_one_reg;
  logic overflow_flag_reg;
  logic out_level_reg;
  logic ack_reg;
  ecctmr_cfg_s cfg;

  assign cfg.mode = ecctmr_mode_e'(timer_mode_control_reg[MODE_LSB +: 2]);
  assign cfg.edge_toggle_enable = timer_mode_control_reg[TOGGLE_BIT];
  assign cfg.clk_sel = prescaler_mode_reg[CLKSEL_LSB +: 2];
  assign cfg.primary_edge_sel = prescaler_mode_reg[ES0_LSB +: 2];
  assign cfg.secondary_edge_sel = prescaler_mode_reg[ES1_LSB +: 2];
  assign cfg.cap0 = capcmp_control_reg[CAP0_BIT];
  assign cfg.reverse_phase_capture = capcmp_control_reg[REV_BIT];
  assign cfg.cap1 = capcmp_control_reg[CAP1_BIT];
  assign cfg.out_enable = output_control_reg[TOE_BIT];
  assign cfg.tog_match0 = output_control_reg[TOM0_BIT];
  assign cfg.tog_match1 = output_control_reg[TOM1_BIT];

  // ****************************************
  // Prescaler and count clock enables
  // ****************************************
  logic [15:0] prs_cnt_reg;
  logic [7:0] cdiv_reg;
  logic sample_en;
  logic tick_a;
  logic tick_b;
  logic tick_c;

  assign sample_en = (prs_cnt_reg == 16'(PRS_DIV - 1));
  assign tick_a = sample_en;
  assign tick_b = sample_en && ((cdiv_reg & CNT_MASK_B) == CNT_MASK_B);
  assign tick_c = sample_en && (cdiv_reg == CNT_MASK_C);

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      prs_cnt_reg <= '0;
      cdiv_reg <= '0;
    end else begin
      prs_cnt_reg <= sample_en ? 16'h0000 : prs_cnt_reg + 16'h0001;
      if (sample_en) begin
        cdiv_reg <= cdiv_reg + 8'h01;
      end
    end
  end

  // ****************************************
  // Filtered pin edges
  // ****************************************
  ecctmr_edge_s pri_edge;
  ecctmr_edge_s sec_edge;

  ecctmr_edge_filt u_pri_filt (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .pin_in(primary_timer_input_in),
    .sample_en_in(sample_en),
    .edge_out(pri_edge)
  );

  ecctmr_edge_filt u_sec_filt (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .pin_in(secondary_timer_input_in),
    .sample_en_in(sample_en),
    .edge_out(sec_edge)
  );

  logic pri_valid;
  logic pri_reverse;
  logic sec_valid;

  assign pri_valid = (cfg.primary_edge_sel == ES_RISE && pri_edge.rise) ||
                     (cfg.primary_edge_sel == ES_FALL && pri_edge.fall) ||
                     (cfg.primary_edge_sel == ES_BOTH && (pri_edge.rise || pri_edge.fall));
  assign pri_reverse = (cfg.primary_edge_sel == ES_RISE && pri_edge.fall) ||
                       (cfg.primary_edge_sel == ES_FALL && pri_edge.rise);
  assign sec_valid = (cfg.secondary_edge_sel == ES_RISE && sec_edge.rise) ||
                     (cfg.secondary_edge_sel == ES_FALL && sec_edge.fall) ||
                     (cfg.secondary_edge_sel == ES_BOTH && (sec_edge.rise || sec_edge.fall));

  // ****************************************
  // Counter events
  // ****************************************
  logic running;
  logic cnt_tick;
  logic edge_clear;
  logic match_clear;
  logic match0;
  logic match1;
  logic cap0_take;
  logic cap1_take;
  logic irq0_evt;
  logic irq1_evt;
  logic toggle_evt;
  logic wrap;

  assign running = (cfg.mode != MODE_STOP);
  // edge as count clock clears continually in mode 10
  assign cnt_tick = running && ((cfg.clk_sel == CKS_DIV_A) ? tick_a :
                                (cfg.clk_sel == CKS_DIV_B) ? tick_b :
                                (cfg.clk_sel == CKS_DIV_C) ? tick_c : pri_valid);
  assign edge_clear = (cfg.mode == MODE_EDGE_CLR) && pri_valid;
  assign match0 = cnt_tick && !cfg.cap0 && (up_counter_reg == capcmp_reg_zero_reg);
  assign match1 = cnt_tick && !cfg.cap1 && (up_counter_reg == capcmp_reg_one_reg);
  assign match_clear = (cfg.mode == MODE_MATCH_CLR) && match0;
  assign cap0_take = running && cfg.cap0 &&
                     (cfg.reverse_phase_capture ? pri_reverse : sec_valid);
  assign cap1_take = running && cfg.cap1 && pri_valid;
  assign irq0_evt = cfg.cap0 ? (running && sec_valid) : match0;
  assign irq1_evt = cfg.cap1 ? cap1_take : match1;
  // toggle on matches or clearing edge
  assign toggle_evt = (cfg.tog_match0 && match0) || (cfg.tog_match1 && match1) ||
                      (cfg.edge_toggle_enable && edge_clear);
  assign wrap = cnt_tick && (up_counter_reg == 16'hffff) && !edge_clear && !match_clear;

  // compare match leaves the count alone except in mode 11, where match zero clears it
  always_comb begin
    up_counter_next = up_counter_reg;
    if (!running) begin
      up_counter_next = RST_CNT16;
    end else if (edge_clear || match_clear) begin
      up_counter_next = RST_CNT16;
    end else if (cnt_tick) begin
      up_counter_next = up_counter_reg + 16'h0001;
    end
  end

  // ****************************************
  // Bus slave decode
  // ****************************************
  logic req;
  logic wr_en;
  logic sel_mode;
  logic sel_prs;
  logic sel_capctl;
  logic sel_outctl;
  logic sel_cr0;
  logic sel_cr1;
  logic ovf_sw_clear;
  logic [31:0] rd_mux;
  logic [15:0] wdata16_cr0;
  logic [15:0] wdata16_cr1;

  // One wait state: the read mux is latched first, the answer comes on the next edge.
  assign req = avs_read_in || avs_write_in;
  assign avs_waitrequest_out = req && !ack_reg;
  assign wr_en = avs_write_in && ack_reg;
  assign sel_mode = wr_en && avs_address_in == OFS_MODE && avs_byteenable_in[0];
  assign sel_prs = wr_en && avs_address_in == OFS_PRESCALE && avs_byteenable_in[0];
  assign sel_capctl = wr_en && avs_address_in == OFS_CAPCTL && avs_byteenable_in[0];
  assign sel_outctl = wr_en && avs_address_in == OFS_OUTCTL && avs_byteenable_in[0];
  assign sel_cr0 = wr_en && avs_address_in == OFS_CR0;
  assign sel_cr1 = wr_en && avs_address_in == OFS_CR1;
  assign ovf_sw_clear = sel_mode && !avs_writedata_in[OVF_BIT];
  assign wdata16_cr0 = {avs_byteenable_in[1] ? avs_writedata_in[15:8] : capcmp_reg_zero_reg[15:8],
                        avs_byteenable_in[0] ? avs_writedata_in[7:0] : capcmp_reg_zero_reg[7:0]};
  assign wdata16_cr1 = {avs_byteenable_in[1] ? avs_writedata_in[15:8] : capcmp_reg_one_reg[15:8],
                        avs_byteenable_in[0] ? avs_writedata_in[7:0] : capcmp_reg_one_reg[7:0]};

  always_comb begin
    case (avs_address_in)
      OFS_MODE: rd_mux = {24'h000000, timer_mode_control_reg[7:1], overflow_flag_reg};
      OFS_PRESCALE: rd_mux = {24'h000000, prescaler_mode_reg};
      OFS_CAPCTL: rd_mux = {24'h000000, capcmp_control_reg};
      OFS_OUTCTL: rd_mux = {24'h000000, output_control_reg};
      OFS_COUNT: rd_mux = {16'h0000, up_counter_reg};
      OFS_CR0: rd_mux = {16'h0000, capcmp_reg_zero_reg};
      OFS_CR1: rd_mux = {16'h0000, capcmp_reg_one_reg};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      ack_reg <= 1'b0;
      avs_readdata_out <= 32'h00000000;
    end else begin
      ack_reg <= req && !ack_reg;
      if (avs_read_in && !ack_reg) begin
        avs_readdata_out <= rd_mux;
      end
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      timer_mode_control_reg <= RST_CTL8;
      prescaler_mode_reg <= RST_CTL8;
      capcmp_control_reg <= RST_CTL8;
      output_control_reg <= RST_CTL8;
    end else begin
      if (sel_mode) begin
        timer_mode_control_reg <= {avs_writedata_in[7:1], 1'b0};
      end
      if (sel_prs) begin
        prescaler_mode_reg <= avs_writedata_in[7:0];
      end
      if (sel_capctl) begin
        capcmp_control_reg <= avs_writedata_in[7:0];
      end
      if (sel_outctl) begin
        output_control_reg <= avs_writedata_in[7:0];
      end
    end
  end

  // ****************************************
  // Counter, captures and overflow
  // ****************************************
  // A capture on the same edge as a software write wins, so a measured value is never lost.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      up_counter_reg <= RST_CNT16;
      capcmp_reg_zero_reg <= RST_CNT16;
      capcmp_reg_one_reg <= RST_CNT16;
      overflow_flag_reg <= 1'b0;
    end else begin
      up_counter_reg <= up_counter_next;
      if (cap0_take) begin
        capcmp_reg_zero_reg <= up_counter_reg;
      end else if (sel_cr0) begin
        capcmp_reg_zero_reg <= wdata16_cr0;
      end
      if (cap1_take) begin
        capcmp_reg_one_reg <= up_counter_reg;
      end else if (sel_cr1) begin
        capcmp_reg_one_reg <= wdata16_cr1;
      end
      // sticky flag, set wins over clear
      overflow_flag_reg <= wrap || (overflow_flag_reg && !ovf_sw_clear);
    end
  end

  // ****************************************
  // Output pin and event pulses
  // ****************************************
  // clear toggle plus match toggle
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      out_level_reg <= 1'b0;
      irq_reg_zero_out <= 1'b0;
      irq_reg_one_out <= 1'b0;
    end else begin
      if (!cfg.out_enable) begin
        out_level_reg <= 1'b0;
      end else if (toggle_evt) begin
        out_level_reg <= !out_level_reg;
      end
      irq_reg_zero_out <= irq0_evt;
      irq_reg_one_out <= irq1_evt;
    end
  end

  // free run with any register use
  assign timer_output_pin_out = out_level_reg;

endmodule

`default_nettype wire

// File: ecctmr_pkg.sv
// Constants and carrier types shared by the edge-cleared capture/compare timer.
package ecctmr_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam int unsigned ADDR_W = 5;
  localparam logic [4:0] OFS_MODE = 5'h00;
  localparam logic [4:0] OFS_PRESCALE = 5'h04;
  localparam logic [4:0] OFS_CAPCTL = 5'h08;
  localparam logic [4:0] OFS_OUTCTL = 5'h0c;
  localparam logic [4:0] OFS_COUNT = 5'h10;
  localparam logic [4:0] OFS_CR0 = 5'h14;
  localparam logic [4:0] OFS_CR1 = 5'h18;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_CTL8 = 8'h00;
  localparam logic [15:0] RST_CNT16 = 16'h0000;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned OVF_BIT = 0;
  localparam int unsigned TOGGLE_BIT = 1;
  localparam int unsigned MODE_LSB = 2;
  localparam int unsigned CLKSEL_LSB = 0;
  localparam int unsigned ES0_LSB = 4;
  localparam int unsigned ES1_LSB = 6;
  localparam int unsigned CAP0_BIT = 0;
  localparam int unsigned REV_BIT = 1;
  localparam int unsigned CAP1_BIT = 2;
  localparam int unsigned TOE_BIT = 0;
  localparam int unsigned TOM0_BIT = 1;
  localparam int unsigned TOM1_BIT = 4;

  // ****************************************
  // Encodings and timing counts
  // ****************************************
  localparam logic [1:0] ES_FALL = 2'h0;
  localparam logic [1:0] ES_RISE = 2'h1;
  localparam logic [1:0] ES_BOTH = 2'h3;
  localparam logic [1:0] CKS_DIV_A = 2'h0;
  localparam logic [1:0] CKS_DIV_B = 2'h1;
  localparam logic [1:0] CKS_DIV_C = 2'h2;
  localparam int unsigned PRS_DIV_DEF = 4;
  localparam logic [7:0] CNT_MASK_B = 8'h03;
  localparam logic [7:0] CNT_MASK_C = 8'hff;

  typedef enum logic [1:0] {MODE_STOP, MODE_FREE, MODE_EDGE_CLR, MODE_MATCH_CLR} ecctmr_mode_e;

  typedef struct packed {
    logic rise;
    logic fall;
  } ecctmr_edge_s;

  typedef struct packed {
    ecctmr_mode_e mode;
    logic edge_toggle_enable;
    logic [1:0] clk_sel;
    logic [1:0] primary_edge_sel;
    logic [1:0] secondary_edge_sel;
    logic cap0;
    logic reverse_phase_capture;
    logic cap1;
    logic out_enable;
    logic tog_match0;
    logic tog_match1;
  } ecctmr_cfg_s;

endpackage

// File: ecctmr_timer_sva.sv
// Port checker for the capture/compare timer, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module ecctmr_timer_chk (
  input wire logic core_clk_in, // Clock.
  input wire logic resetn_in, // Reset, active low.
  input wire logic [ecctmr_pkg::ADDR_W-1:0] avs_address_in, // Address.
  input wire logic avs_read_in, // Read.
  input wire logic avs_write_in, // Write.
  input wire logic [31:0] avs_writedata_in, // Write data.
  input wire logic [3:0] avs_byteenable_in, // Lanes.
  input wire logic [31:0] avs_readdata_out, // Read data.
  input wire logic avs_waitrequest_out, // Stall.
  input wire logic primary_timer_input_in, // Primary pin.
  input wire logic secondary_timer_input_in, // Secondary pin.
  input wire logic timer_output_pin_out, // Output pin.
  input wire logic irq_reg_zero_out, // Event zero.
  input wire logic irq_reg_one_out // Event one.
);
  import ecctmr_pkg::*;
  logic [15:0] cr0_reg;
  logic [7:0] mode_reg;
  logic [7:0] capctl_reg;
  logic ovf_seen_reg;
  wire logic wr_ok = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
  wire logic rd_ok = avs_read_in && !avs_waitrequest_out;
  wire logic rd_mode = rd_ok && avs_address_in == OFS_MODE;
  // Only the single-pulse setup is judged, since other setups give other spacings.
  wire logic pulse_cfg = cr0_reg == 16'h0003 && mode_reg[3:1] == 3'h5 && capctl_reg[2:0] == 3'h4;
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      cr0_reg <= RST_CNT16;
      mode_reg <= RST_CTL8;
      capctl_reg <= RST_CTL8;
      ovf_seen_reg <= 1'b0;
    end else begin
      if (wr_ok && avs_address_in == OFS_CR0) cr0_reg <= avs_writedata_in[15:0];
      if (wr_ok && avs_address_in == OFS_CAPCTL) capctl_reg <= avs_writedata_in[7:0];
      if (wr_ok && avs_address_in == OFS_MODE) begin
        mode_reg <= avs_writedata_in[7:0];
        ovf_seen_reg <= ovf_seen_reg && avs_writedata_in[OVF_BIT];
      end else if (rd_mode && avs_readdata_out[OVF_BIT]) begin
        ovf_seen_reg <= 1'b1;
      end
    end
  end
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);
  sequence s_req_accept;
    avs_waitrequest_out ##1 !avs_waitrequest_out;
  endsequence
  sequence s_match_back;
    ##4 (irq_reg_zero_out && timer_output_pin_out != $past(timer_output_pin_out, 4));
  endsequence
  a_irq0_pulse: assert property (irq_reg_zero_out |=> !irq_reg_zero_out)
    else $error("irq zero held longer than one cycle");
  a_irq1_pulse: assert property (irq_reg_one_out |=> !irq_reg_one_out)
    else $error("irq one held longer than one cycle");
  a_req_wait: assert property ($rose(avs_read_in || avs_write_in) |-> s_req_accept)
    else $error("request not answered after one wait state");
  a_data_stands: assert property ($fell(avs_read_in) |-> $stable(avs_readdata_out))
    else $error("read data moved after the read");
  a_unmapped_zero: assert property (rd_ok && avs_address_in > OFS_CR1 |-> avs_readdata_out == 32'h0)
    else $error("unmapped read not zero");
  a_pin_off: assert property (wr_ok && avs_address_in == OFS_OUTCTL && !avs_writedata_in[TOE_BIT]
    |-> ##2 (!timer_output_pin_out) [*3])
    else $error("output pin driven while disabled");
  a_ovf_sticky: assert property (rd_mode && ovf_seen_reg |-> avs_readdata_out[OVF_BIT])
    else $error("overflow flag dropped without a clear");
  a_width_four: assert property (pulse_cfg && irq_reg_one_out |-> s_match_back)
    else $error("clear and match not four ticks apart");
endmodule
bind ecctmr_timer ecctmr_timer_chk ecctmr_timer_chk_i (.core_clk_in, .resetn_in, .avs_address_in, .avs_read_in,
  .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
  .primary_timer_input_in, .secondary_timer_input_in, .timer_output_pin_out, .irq_reg_zero_out, .irq_reg_one_out);
`default_nettype wire

// File: ecctmr_pin_src.sv
// Pulse source model that drives the two timer input pins.
`timescale 1ns/1ps
`default_nettype none
module ecctmr_pin_src (
  input wire logic core_clk_in, // Bench clock.
  output logic primary_out, // Primary pin level.
  output logic secondary_out // Secondary pin level.
);
  initial begin
    primary_out = 1'b0;
    secondary_out = 1'b0;
  end
  task automatic drive(input logic sec, input logic level, input int hold);
    int n;
    n = hold < 4 ? 4 : hold;
    @(posedge core_clk_in);
    if (sec) secondary_out <= level;
    else primary_out <= level;
    repeat (n) @(posedge core_clk_in);
  endtask
endmodule
`default_nettype wire

// File: ecctmr_timer_test.sv
// Self-checking bench for the edge-cleared capture/compare timer.
`timescale 1ns/1ps
`default_nettype none
module ecctmr_timer_test;
  import ecctmr_pkg::*;
  localparam int LIMIT = 80000;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hf;
  logic [31:0] seed = 32'hdd4e;
  logic [31:0] rdata, got;
  logic [15:0] cr0;
  logic waitreq, pri, sec, pin, irq0, irq1, pin_before;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n_irq0 = 0;
  int n_irq1 = 0;
  int t_irq0, t_irq1, h, c0, c1;
  // Expected capture values, queued by the model as each pulse is planned.
  int exp_q[$];
  ecctmr_timer #(.PRS_DIV(1)) ecctmr_timer_i (.core_clk_in(core_clk), .resetn_in(resetn),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
    .primary_timer_input_in(pri), .secondary_timer_input_in(sec), .timer_output_pin_out(pin),
    .irq_reg_zero_out(irq0), .irq_reg_one_out(irq1));
  ecctmr_pin_src ecctmr_pin_src_i (.core_clk_in(core_clk), .primary_out(pri), .secondary_out(sec));
  always #2 core_clk = ~core_clk;
  // Events are counted on the falling edge, where all outputs have settled.
  always @(negedge core_clk) begin
    cyc++;
    if (irq0 === 1'b1) begin
      n_irq0++;
      t_irq0 = cyc;
    end
    if (irq1 === 1'b1) begin
      n_irq1++;
      t_irq1 = cyc;
    end
    if (cyc == LIMIT) begin
      n_mismatch++;
      complete_run();
    end
  end
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic bus(input logic is_wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    if (is_wr) wr <= 1'b1;
    else rd <= 1'b1;
    @(posedge core_clk);
    while (waitreq !== 1'b0) @(posedge core_clk);
    got = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    samples_checked++;
    if (got !== e) begin
      n_mismatch++;
      $display("Error at %0t: address %h expected %h got %h", $time, a, e, got);
    end
  endtask
  task automatic check_val(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    for (int a = 0; a < 32; a += 4) rd_chk(5'(a), 32'h0);
    $display("test reset done");
    // count clock stays on the sample tick
    bus(1'b1, OFS_CR0, 32'h3);
    bus(1'b1, OFS_CAPCTL, 32'h4);
    bus(1'b1, OFS_OUTCTL, 32'h13);
    bus(1'b1, OFS_PRESCALE, 32'h90);
    bus(1'b1, OFS_MODE, 32'h0a);
    repeat (40) @(posedge core_clk);
    c1 = n_irq1;
    pin_before = pin;
    ecctmr_pin_src_i.drive(1'b0, 1'b1, 20);
    check_val(32'(c1 + 1), 32'(n_irq1));
    check_val(32'(t_irq1 + 4), 32'(t_irq0));
    check_val(32'h1, {31'h0, pin_before});
    check_val(32'h1, {31'h0, pin});
    $display("test clear_pulse done");
    bus(1'b1, OFS_OUTCTL, 32'h0);
    bus(1'b1, OFS_CAPCTL, 32'h7);
    bus(1'b1, OFS_PRESCALE, 32'h40);
    ecctmr_pin_src_i.drive(1'b0, 1'b0, 30);
    c0 = n_irq0;
    seed = xorshift(seed);
    h = 8 + int'(seed[4:0]);
    exp_q.push_back(h + 1);
    ecctmr_pin_src_i.drive(1'b0, 1'b1, h);
    ecctmr_pin_src_i.drive(1'b0, 1'b0, 30);
    bus(1'b0, OFS_CR0, 32'h0);
    cr0 = got[15:0];
    bus(1'b0, OFS_CR1, 32'h0);
    check_val(32'(exp_q.pop_front()), {16'h0, got[15:0] - cr0});
    check_val(32'(c0), 32'(n_irq0));
    ecctmr_pin_src_i.drive(1'b1, 1'b1, 20);
    check_val(32'(c0 + 1), 32'(n_irq0));
    rd_chk(OFS_CR0, {16'h0, cr0});
    $display("test pulse_width done");
    bus(1'b1, OFS_CAPCTL, 32'h5);
    bus(1'b1, OFS_PRESCALE, 32'h10);
    bus(1'b1, OFS_MODE, 32'h04);
    c0 = n_irq0;
    c1 = n_irq1;
    seed = xorshift(seed);
    h = 8 + int'(seed[4:0]);
    exp_q.push_back(h + 1);
    ecctmr_pin_src_i.drive(1'b1, 1'b0, h);
    ecctmr_pin_src_i.drive(1'b0, 1'b1, 20);
    bus(1'b0, OFS_CR0, 32'h0);
    cr0 = got[15:0];
    bus(1'b0, OFS_CR1, 32'h0);
    check_val(32'(exp_q.pop_front()), {16'h0, got[15:0] - cr0});
    check_val(32'(c0 + 1), 32'(n_irq0));
    check_val(32'(c1 + 1), 32'(n_irq1));
    $display("test dual_capture done");
    // The count restarts at zero on each edge, so the second capture holds one less than the spacing.
    bus(1'b1, OFS_PRESCALE, 32'hb0);
    bus(1'b1, OFS_OUTCTL, 32'h13);
    bus(1'b1, OFS_MODE, 32'h0a);
    c1 = n_irq1;
    seed = xorshift(seed);
    h = 8 + int'(seed[4:0]);
    exp_q.push_back(h);
    ecctmr_pin_src_i.drive(1'b0, 1'b0, h);
    check_val(32'h1, {31'h0, pin});
    ecctmr_pin_src_i.drive(1'b0, 1'b1, 20);
    rd_chk(OFS_CR1, 32'(exp_q.pop_front()));
    check_val(32'(c1 + 2), 32'(n_irq1));
    check_val(32'h0, {31'h0, pin});
    $display("test both_edges done");
    bus(1'b1, OFS_MODE, 32'h0);
    bus(1'b1, OFS_CAPCTL, 32'h0);
    bus(1'b1, OFS_CR0, 32'h3);
    bus(1'b1, OFS_PRESCALE, 32'h81);
    bus(1'b1, OFS_MODE, 32'h0c);
    repeat (40) @(posedge core_clk);
    c0 = t_irq0;
    repeat (16) @(posedge core_clk);
    check_val(32'(c0 + 16), 32'(t_irq0));
    bus(1'b1, OFS_PRESCALE, 32'h80);
    $display("test match_clear done");
    bus(1'b1, OFS_MODE, 32'h0);
    bus(1'b1, OFS_CAPCTL, 32'h0);
    bus(1'b1, OFS_CR0, 32'h100);
    bus(1'b1, OFS_CR1, 32'h200);
    bus(1'b1, OFS_OUTCTL, 32'h13);
    c0 = n_irq0;
    c1 = n_irq1;
    bus(1'b1, OFS_MODE, 32'h04);
    repeat (65000) @(posedge core_clk);
    rd_chk(OFS_MODE, 32'h4);
    check_val(32'(c0 + 1), 32'(n_irq0));
    check_val(32'(c1 + 1), 32'(n_irq1));
    repeat (600) @(posedge core_clk);
    rd_chk(OFS_MODE, 32'h5);
    rd_chk(OFS_MODE, 32'h5);
    bus(1'b1, OFS_MODE, 32'h04);
    rd_chk(OFS_MODE, 32'h4);
    $display("test overflow done");
    complete_run();
  end
endmodule
`default_nettype wire
